// ===== hdl/tap_decoder_top.sv
/*
 Instruction decoder and data register selection of the test access port.
 Assumes the test pins and memory pin levels arrive from outside the clk
 domain; the test clock is sampled by clk and its edges detected.
*/
`timescale 1ns/10ps
`include "tap_params.svh"
module tap_decoder_top
   import tap_pkg::*;
(
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  ce,
   input  wire logic                  sys_rst,
   // Test port pins
   input  wire logic                  tck,
   input  wire logic                  tms,
   input  wire logic                  tdi,
   output logic                       tdo,
   output logic                       tdo_oe,
   // Memory pin ring
   input  wire logic [`BSR_LEN-1:0]   ring_levels,
   output logic      [`BSR_LEN-1:0]   ring_drive,
   output logic                       ring_drive_en,
   output logic                       outputs_hiz,
   // Status
   output logic      [`IR_LEN-1:0]    active_code
);

   ////////////////////////////////////////////////////////////////////////
   // Synchronisers and edge detection

   logic [2:0]          tck_q;
   logic [1:0]          tms_q;
   logic [1:0]          tdi_q;
   logic [`BSR_LEN-1:0] ring_s1_q;
   logic [`BSR_LEN-1:0] ring_s2_q;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tck_q     <= 3'h0;
         tms_q     <= 2'h3;
         tdi_q     <= 2'h3;
         ring_s1_q <= '0;
         ring_s2_q <= '0;
      end else if (ce) begin
         tck_q     <= {tck_q[1:0], tck};
         tms_q     <= {tms_q[0], tms};
         tdi_q     <= {tdi_q[0], tdi};
         ring_s1_q <= ring_levels;
         ring_s2_q <= ring_s1_q;
      end
   end

   tap_ctl_if ctl ();

   wire tck_rise = tck_q[1] & ~tck_q[2];
   wire tck_fall = ~tck_q[1] & tck_q[2];
   wire tdi_s    = tdi_q[1];

   assign ctl.tck_rise = tck_rise;
   assign ctl.tck_fall = tck_fall;
   assign ctl.tms_s    = tms_q[1];

   tap_state_tracker u_fsm (
      .clk     (clk),
      .ce      (ce),
      .sys_rst (sys_rst),
      .ctl     (ctl)
   );

   ////////////////////////////////////////////////////////////////////////
   // Instruction decode

   function automatic path_sel_type path_of(input logic [`IR_LEN-1:0] code);
      case (code)
         `IR_EXTEST, `IR_SAMPLE_Z, `IR_SAMPLE: path_of = PATH_BSR;
         `IR_IDCODE:                           path_of = PATH_ID;
         default:                              path_of = PATH_BYPASS;
      endcase
   endfunction

   logic [`IR_LEN-1:0]  ir_shift_q;
   logic [`IR_LEN-1:0]  active_q;
   logic                bypass_q;
   logic [`ID_LEN-1:0]  id_q;
   logic [`BSR_LEN-1:0] bsr_q;
   logic [`BSR_LEN-1:0] drive_q;
   logic                drive_en_q;
   logic                hiz_q;
   logic                tdo_q;
   logic                tdo_oe_q;

   tap_state_type st;
   assign st = ctl.state;

   path_sel_type active_sel;
   assign active_sel = path_of(active_q);

   wire in_shift_ir = (st == SHIFT_IR);
   wire in_shift_dr = (st == SHIFT_DR);
   wire [`BSR_LEN-1:0] cap_val = (ring_s2_q & `BSR_PIN_MASK)
                               | (`BSR_DEFAULT & ~`BSR_PIN_MASK);
   wire dr_bit = (active_sel == PATH_BSR) ? bsr_q[0]
               : (active_sel == PATH_ID)  ? id_q[0] : bypass_q;
   wire load_drive = tck_fall && ((st == UPDATE_IR && ir_shift_q == `IR_EXTEST)
                     || (st == UPDATE_DR && active_sel == PATH_BSR));

   ////////////////////////////////////////////////////////////////////////
   // Instruction register

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ir_shift_q <= `IR_IDCODE;
         active_q   <= `IR_IDCODE;
      end else if (ce) begin
         if (tck_rise && st == CAPTURE_IR) begin
            ir_shift_q <= {1'b0, `IR_CAPTURE_LSBS};
         end else if (tck_rise && in_shift_ir) begin
            ir_shift_q <= {tdi_s, ir_shift_q[`IR_LEN-1:1]};
         end
         if (st == TEST_LOGIC_RESET) begin
            active_q <= `IR_IDCODE;
         end else if (tck_fall && st == UPDATE_IR) begin
            active_q <= ir_shift_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Data registers

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bypass_q <= 1'b0;
         id_q     <= '0;
         bsr_q    <= '0;
      end else if (ce && tck_rise) begin
         if (st == CAPTURE_DR) begin
            case (active_sel)
               PATH_ID:  id_q     <= `ID_VALUE;
               PATH_BSR: bsr_q    <= cap_val;
               default:  bypass_q <= 1'b0;
            endcase
         end else if (in_shift_dr) begin
            case (active_sel)
               PATH_ID:  id_q     <= {tdi_s, id_q[`ID_LEN-1:1]};
               PATH_BSR: bsr_q    <= {tdi_s, bsr_q[`BSR_LEN-1:1]};
               default:  bypass_q <= tdi_s;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Serial output and pin ring control

   // Memory inputs are never gated here, so the core keeps following them
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tdo_q      <= 1'b0;
         tdo_oe_q   <= 1'b0;
         drive_q    <= '0;
         drive_en_q <= 1'b0;
         hiz_q      <= 1'b0;
      end else if (ce) begin
         if (tck_fall) begin
            tdo_q    <= in_shift_ir ? ir_shift_q[0] : dr_bit;
            tdo_oe_q <= in_shift_ir | in_shift_dr;
         end
         if (load_drive) begin
            drive_q <= bsr_q;
         end
         drive_en_q <= (active_q == `IR_EXTEST);
         hiz_q      <= (active_q == `IR_SAMPLE_Z);
      end
   end

   assign tdo           = tdo_q;
   assign tdo_oe        = tdo_oe_q;
   assign ring_drive    = drive_q;
   assign ring_drive_en = drive_en_q;
   assign outputs_hiz   = hiz_q;
   assign active_code   = active_q;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_ir_capture_bits: assert property (
      (ce && tck_rise && st == CAPTURE_IR) |=> ir_shift_q[1:0] == 2'h1)
      else $error("capture did not load 01");

   a_ir_shift_path: assert property (
      (ce && tck_rise && in_shift_ir) |=> ir_shift_q[2] == $past(tdi_s)
         && ir_shift_q[1:0] == $past(ir_shift_q[2:1]))
      else $error("instruction shift wrong");

   a_active_only_update: assert property (
      $changed(active_q) |-> $past(st) == TEST_LOGIC_RESET
         || ($past(tck_fall) && $past(st) == UPDATE_IR))
      else $error("instruction changed outside update");

   a_ir_load_serial: assert property (
      $changed(ir_shift_q) |-> $past(st) == CAPTURE_IR || $past(st) == SHIFT_IR)
      else $error("instruction register loaded outside serial path");

   a_bypass_path: assert property (
      (ce && tck_rise && in_shift_dr && active_sel == PATH_BYPASS)
         |=> bypass_q == $past(tdi_s))
      else $error("bypass not in path");

   a_reserved_bypass: assert property (
      (ce && tck_fall && in_shift_dr && (active_q == `IR_RSVD_LO
         || active_q == `IR_RSVD_HI || active_q == `IR_PRIVATE))
         |=> tdo_q == $past(bypass_q))
      else $error("reserved code not bypass");

   a_bsr_capture: assert property (
      (ce && tck_rise && st == CAPTURE_DR && active_sel == PATH_BSR)
         |=> bsr_q == $past(cap_val) && (bsr_q & ~`BSR_PIN_MASK) == `BSR_DEFAULT)
      else $error("boundary capture wrong");

   a_id_capture: assert property (
      (ce && tck_rise && st == CAPTURE_DR && active_q == `IR_IDCODE)
         |=> id_q == `ID_VALUE)
      else $error("identification capture wrong");

   a_reset_idcode: assert property (
      (ce && st == TEST_LOGIC_RESET) |=> active_q == `IR_IDCODE)
      else $error("identification not default");

   a_extest_drive: assert property (
      (ce && tck_fall && st == UPDATE_IR && ir_shift_q == `IR_EXTEST)
         |=> drive_q == $past(bsr_q) ##1 drive_en_q)
      else $error("external test drive wrong");

   a_hiz_follow: assert property (
      (ce && active_q == `IR_SAMPLE_Z) |=> hiz_q)
      else $error("outputs not floated");

   a_tdo_on_fall: assert property (
      $changed(tdo_q) |-> $past(tck_fall) && $past(ce))
      else $error("serial output changed off falling edge");

endmodule

// ===== hdl/tap_state_tracker.sv
/*
 Port state machine, advanced on each detected rising test-clock edge.
 Assumes edge pulses and mode select already synchronised to clk.
*/
`timescale 1ns/10ps
module tap_state_tracker
   import tap_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic ce,
   input wire logic sys_rst,
   // Decoder side
   tap_ctl_if.ctrl  ctl
);

   tap_state_type state_q;
   tap_state_type state_d;

   assign ctl.state = state_q;

   always_comb begin
      state_d = state_q;
      case (state_q)
         TEST_LOGIC_RESET: state_d = ctl.tms_s ? TEST_LOGIC_RESET : RUN_IDLE;
         RUN_IDLE:         state_d = ctl.tms_s ? SELECT_DR : RUN_IDLE;
         SELECT_DR:        state_d = ctl.tms_s ? SELECT_IR : CAPTURE_DR;
         CAPTURE_DR:       state_d = ctl.tms_s ? EXIT1_DR : SHIFT_DR;
         SHIFT_DR:         state_d = ctl.tms_s ? EXIT1_DR : SHIFT_DR;
         EXIT1_DR:         state_d = ctl.tms_s ? UPDATE_DR : PAUSE_DR;
         PAUSE_DR:         state_d = ctl.tms_s ? EXIT2_DR : PAUSE_DR;
         EXIT2_DR:         state_d = ctl.tms_s ? UPDATE_DR : SHIFT_DR;
         UPDATE_DR:        state_d = ctl.tms_s ? SELECT_DR : RUN_IDLE;
         SELECT_IR:        state_d = ctl.tms_s ? TEST_LOGIC_RESET : CAPTURE_IR;
         CAPTURE_IR:       state_d = ctl.tms_s ? EXIT1_IR : SHIFT_IR;
         SHIFT_IR:         state_d = ctl.tms_s ? EXIT1_IR : SHIFT_IR;
         EXIT1_IR:         state_d = ctl.tms_s ? UPDATE_IR : PAUSE_IR;
         PAUSE_IR:         state_d = ctl.tms_s ? EXIT2_IR : PAUSE_IR;
         EXIT2_IR:         state_d = ctl.tms_s ? UPDATE_IR : SHIFT_IR;
         UPDATE_IR:        state_d = ctl.tms_s ? SELECT_DR : RUN_IDLE;
         default:          state_d = TEST_LOGIC_RESET;
      endcase
   end

   // Power-up reset stands in for the missing test reset pin
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q <= TEST_LOGIC_RESET;
      end else if (ce && ctl.tck_rise) begin
         state_q <= state_d;
      end
   end

endmodule

// ===== pkg/tap_ctl_if.sv
/*
 Carrier between the decoder and its port state machine.
 Assumes both ends run on the same system clock.
*/
`timescale 1ns/10ps
interface tap_ctl_if;
   import tap_pkg::*;

   logic          tck_rise;
   logic          tck_fall;
   logic          tms_s;
   tap_state_type state;

   modport ctrl (input tck_rise, input tck_fall, input tms_s, output state);
   modport dec  (output tck_rise, output tck_fall, output tms_s, input state);
endinterface

// ===== pkg/tap_params.svh
/*
 Constants of the test access port decoder: instruction codes, register
 lengths, capture defaults. Assumes inclusion by the design files and the testbench.
*/
// Summary of operation
// - Capture-instruction loads the two low instruction bits with 01.
// - Shift-instruction puts the instruction register between serial in and out.
// - A new instruction takes effect only in update-instruction.
// - Code 111 puts the one-bit bypass register in the serial path.
// - Code 100 captures pin levels into boundary scan, then shifts it.
// - Boundary positions without a pin capture their fixed default.
// - Code 000 selects external test with boundary scan in the path.
// - External test does not isolate memory inputs from the core.
// - External test drives boundary contents out on falling edge in update-instruction.
// - External test capture loads pins and defaults in parallel on rising edge.
// - Code 001 captures the identification value and shifts it out.
// - Identification becomes active at power-up and in test-logic-reset.
// - Code 010 floats memory outputs and uses boundary scan in the path.
// - Reserved codes 011 and 110 act exactly as bypass.
// - Codes are binary, most significant bit on the left.
// - Instruction register is three bits, loadable only in the serial path.
// - Identification register is 32 bits, bit 0 leaves first.
// - No test reset pin; five high mode-select edges or power-up reset.
// - Inputs sampled on rising test clock; output changes after falling edge.
`ifndef TAP_PARAMS_SVH
`define TAP_PARAMS_SVH

`define IR_LEN          3
`define IR_EXTEST       3'h0
`define IR_IDCODE       3'h1
`define IR_SAMPLE_Z     3'h2
`define IR_RSVD_LO      3'h3
`define IR_SAMPLE       3'h4
`define IR_PRIVATE      3'h5
`define IR_RSVD_HI      3'h6
`define IR_BYPASS       3'h7
`define IR_CAPTURE_LSBS 2'h1

// Identification value is arbitrary; bit 0 is the presence bit
`define ID_LEN          32
`define ID_VALUE        32'h0000_0A5B

`define BSR_LEN         16
`define BSR_PIN_MASK    16'h3FFF
`define BSR_DEFAULT     16'hC000

`endif

// ===== pkg/tap_pkg.sv
/*
 Types of the test access port decoder.
 Assumes nothing of its surroundings.
*/
package tap_pkg;

   typedef enum logic [3:0] {
      TEST_LOGIC_RESET, RUN_IDLE,
      SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPDATE_DR,
      SELECT_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPDATE_IR
   } tap_state_type;

   typedef enum logic [1:0] {
      PATH_BYPASS, PATH_ID, PATH_BSR
   } path_sel_type;

endpackage

// ===== testbench/tap_host_model.sv
/*
 Board-level scan controller: drives test clock, mode select and serial data.
 Assumes the device answers on its serial output after each falling test-clock edge.
*/
`timescale 1ns/10ps
module tap_host_model (
   // Test port pins
   output logic        tck,
   output logic        tms,
   output logic        tdi,
   input  wire logic   tdo,
   // Scan result
   output logic [31:0] scan_out,
   output logic        scan_done
);
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      tck       = 1'b0;
      tms       = 1'b1;
      tdi       = 1'b1;
      scan_out  = '0;
      scan_done = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // One period: inputs move after the fall, output read just before the rise
   task automatic step(input logic m, input logic d, output logic q);
      #20;
      tms = m;
      tdi = d;
      #80;
      q   = tdo;
      tck = 1'b1;
      #60;
      tck = 1'b0;
   endtask

   task automatic step_tms(input logic m);
      logic q;
      step(m, 1'b1, q);
   endtask

   // From Run-Test/Idle into a shift state, n bits LSB first, ends in Exit1
   task automatic scan(input logic ir, input int n, input logic [31:0] din);
      logic q;
      scan_out = '0;
      step_tms(1'b1);
      if (ir) begin
         step_tms(1'b1);
      end
      step_tms(1'b0);
      step_tms(1'b0);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], q);
         scan_out[i] = q;
      end
      tdi       = 1'b1;
      scan_done = 1'b1;
      #1 scan_done = 1'b0;
   endtask

   // Exit1 through Update back to Run-Test/Idle
   task automatic finish_scan();
      step_tms(1'b1);
      step_tms(1'b0);
   endtask

   task automatic reset_tap();
      repeat (5) step_tms(1'b1);
   endtask
endmodule

// ===== testbench/test_tap_decoder_top.sv
/*
 Self-checking bench of the instruction decoder: scans every code and path.
 Assumes the host model as the only driver of the test port pins.
*/
`timescale 1ns/10ps
`include "tap_params.svh"
module test_tap_decoder_top;
   import tap_pkg::*;

   logic                clk, ce, sys_rst, tck, tms, tdi, tdo, tdo_oe;
   logic                ring_drive_en, outputs_hiz, scan_done;
   logic [`BSR_LEN-1:0] ring_levels, ring_drive, pattern;
   logic [`IR_LEN-1:0]  active_code;
   logic [31:0]         scan_out, din;
   logic [31:0]         expect_q[$];
   logic [2:0]          order[8] = '{`IR_SAMPLE, `IR_EXTEST, `IR_SAMPLE_Z, `IR_IDCODE,
                                     `IR_RSVD_LO, `IR_PRIVATE, `IR_RSVD_HI, `IR_BYPASS};
   int                  fails = 0;
   int                  n_compared = 0;
   int                  seed = 32'hb265;

   tap_decoder_top tap_decoder_top_inst (.clk(clk), .ce(ce), .sys_rst(sys_rst), .tck(tck),
      .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .ring_levels(ring_levels),
      .ring_drive(ring_drive), .ring_drive_en(ring_drive_en), .outputs_hiz(outputs_hiz),
      .active_code(active_code));

   tap_host_model tap_host_model_inst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
      .scan_out(scan_out), .scan_done(scan_done));

   initial clk = 1'b0;
   always #10 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check_pin(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (exp !== got) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic check_scan(input logic [31:0] exp, input logic [31:0] got);
      check_pin("scan_out", exp, got);
   endtask

   // Oldest noted result against each finished scan
   always @(posedge scan_done) begin
      if (expect_q.size() == 0) begin
         check_pin("unexpected_scan", 32'h0, 32'h1);
      end else begin
         check_scan(expect_q.pop_front(), scan_out);
      end
      check_pin("tdo_oe", 32'h1, tdo_oe);
   end

   task automatic close_out();
      if (expect_q.size() != 0) begin
         fails++;
      end
      $display("Compared %0d, failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic load_ir(input logic [2:0] c);
      logic [2:0] prev;
      prev = active_code;
      expect_q.push_back(32'h1);
      tap_host_model_inst.scan(1'b1, `IR_LEN, {29'h0, c});
      check_pin("held_code", prev, active_code);
      tap_host_model_inst.finish_scan();
      check_pin("tdo_oe", 32'h0, tdo_oe);
      check_pin("active_code", c, active_code);
      check_pin("outputs_hiz", c == `IR_SAMPLE_Z, outputs_hiz);
      check_pin("ring_drive_en", c == `IR_EXTEST, ring_drive_en);
      if (c == `IR_EXTEST) begin
         check_pin("ring_drive", pattern, ring_drive);
      end
   endtask

   task automatic scan_dr(input logic [2:0] c);
      int          n;
      logic [31:0] exp;
      @(posedge clk);
      #2 ring_levels = $random(seed);
      din = $random(seed);
      case (c)
         `IR_IDCODE: begin
            n   = `ID_LEN;
            exp = `ID_VALUE;
         end
         `IR_EXTEST, `IR_SAMPLE_Z, `IR_SAMPLE: begin
            n   = `BSR_LEN;
            exp = {16'h0, ring_levels & `BSR_PIN_MASK | `BSR_DEFAULT};
            pattern = din[15:0];
         end
         default: begin
            n   = 8;
            exp = {24'h0, din[6:0], 1'b0};
         end
      endcase
      expect_q.push_back(exp);
      tap_host_model_inst.scan(1'b0, n, din);
      tap_host_model_inst.finish_scan();
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      ce          = 1'b1;
      sys_rst     = 1'b1;
      ring_levels = '0;
      pattern     = '0;
      din         = '0;
      repeat (6) @(posedge clk);
      #2 sys_rst = 1'b0;
      check_pin("active_code", `IR_IDCODE, active_code);
      check_pin("ring_drive_en", 32'h0, ring_drive_en);
      tap_host_model_inst.step_tms(1'b0);
      scan_dr(`IR_IDCODE);
      foreach (order[i]) begin
         load_ir(order[i]);
         scan_dr(order[i]);
      end
      // Clock enable low: the reset sequence must leave no trace
      ce = 1'b0;
      tap_host_model_inst.reset_tap();
      ce = 1'b1;
      check_pin("frozen_code", `IR_BYPASS, active_code);
      tap_host_model_inst.reset_tap();
      check_pin("active_code", `IR_IDCODE, active_code);
      tap_host_model_inst.step_tms(1'b0);
      scan_dr(`IR_IDCODE);
      repeat (4) @(posedge clk);
      close_out();
   end

   initial begin
      for (int i = 0; i < 100000; i++) begin
         @(posedge clk);
      end
      check_pin("watchdog", 32'h0, 32'h1);
      close_out();
   end
endmodule
